// file: src/dso_pkg.sv
// Overview of operation
// - code 1: any fault but the two comm errors
// - code 2: frequency from reference minus width up to reference
// - code 3: frequency within level plus or minus width
// - code 4: on above level plus width, off below level
// - code 5: inverse of code 4 hysteresis
// - code 6: on during automatic restart
// - code 9: on while output stage blocked
// - codes 12, 25: over-torque and low-torque detection
// - code 18: run source setting equals 3
// - code 19: internal controller logic level
// - code 20: on at zero speed
// - code 21: no fault and drive ready
// - code 22: bus voltage below low-voltage level
// - code 23: local run mode
// - code 24: local reference mode
// - code 26: reference loss detected
// - loss: setting 0 stops, 1 runs at ratio of last reference
// - code 27: timer function result
// - code 30: second motor set selected
// - code 31: zero servo enabled and load locked
// - code 32: communication control of outputs active
// - level 0.0-400.0 Hz, 1200.0 Hz high range; width 0.1-25.5 Hz
// - code 0: run command on or output frequency above zero
package dso_pkg;
    // data widths, frequencies in 0.1 Hz steps
    localparam int FREQ_W = 14;
    localparam int WID_W = 8;
    localparam int VOLT_W = 10;
    localparam int FUNC_W = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int N_TERM = 3;

    // word addresses
    localparam logic [3:0] ADR_FUNC0 = 4'h0;
    localparam logic [3:0] ADR_FUNC1 = 4'h1;
    localparam logic [3:0] ADR_FUNC2 = 4'h2;
    localparam logic [3:0] ADR_LEVEL = 4'h3;
    localparam logic [3:0] ADR_WIDTH = 4'h4;
    localparam logic [3:0] ADR_CTRL = 4'h5;
    localparam logic [3:0] ADR_RATIO = 4'h6;
    localparam logic [3:0] ADR_FMIN = 4'h7;
    localparam logic [3:0] ADR_UVLEV = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'h9;

    // control register fields
    localparam int CTRL_HF = 0;
    localparam int CTRL_RUN_LO = 1;
    localparam int CTRL_REF_LO = 3;
    localparam int CTRL_LOSS = 5;
    localparam int CTRL_LR_EN = 6;

    // status register fields
    localparam int ST_OUT_LO = 0;
    localparam int ST_DET1 = 3;
    localparam int ST_LOC_RUN = 4;
    localparam int ST_LOC_REF = 5;
    localparam int ST_LOSS = 6;

    // value limits
    localparam logic [13:0] LEVEL_MAX = 14'h0FA0;
    localparam logic [13:0] LEVEL_MAX_HF = 14'h2EE0;
    localparam logic [7:0] WIDTH_MIN = 8'h01;
    localparam logic [1:0] SRC_LOCAL = 2'h0;
    localparam logic [1:0] SRC_CTRL = 2'h3;
    localparam logic [7:0] RATIO_DIV = 8'h64;

    // reset values
    localparam logic [5:0] FUNC_RST = 6'h00;
    localparam logic [13:0] LEVEL_RST = 14'h0000;
    localparam logic [7:0] WIDTH_RST = 8'h14;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [7:0] RATIO_RST = 8'h50;
    localparam logic [13:0] FMIN_RST = 14'h0005;
    localparam logic [9:0] UVLEV_RST = 10'h0BE;

    // output function codes
    localparam logic [5:0] FN_RUNNING = 6'h00;
    localparam logic [5:0] FN_FAULT = 6'h01;
    localparam logic [5:0] FN_AGREE = 6'h02;
    localparam logic [5:0] FN_SET_AGREE = 6'h03;
    localparam logic [5:0] FN_DET1 = 6'h04;
    localparam logic [5:0] FN_DET2 = 6'h05;
    localparam logic [5:0] FN_RESTART = 6'h06;
    localparam logic [5:0] FN_BLOCK = 6'h09;
    localparam logic [5:0] FN_OVER_TQ = 6'h0C;
    localparam logic [5:0] FN_CTRL_SRC = 6'h12;
    localparam logic [5:0] FN_CTRL_OUT = 6'h13;
    localparam logic [5:0] FN_ZERO_SPD = 6'h14;
    localparam logic [5:0] FN_READY = 6'h15;
    localparam logic [5:0] FN_UNDERV = 6'h16;
    localparam logic [5:0] FN_LOC_RUN = 6'h17;
    localparam logic [5:0] FN_LOC_REF = 6'h18;
    localparam logic [5:0] FN_UNDER_TQ = 6'h19;
    localparam logic [5:0] FN_REF_LOSS = 6'h1A;
    localparam logic [5:0] FN_TIMER = 6'h1B;
    localparam logic [5:0] FN_MOTOR2 = 6'h1E;
    localparam logic [5:0] FN_ZSERVO = 6'h1F;
    localparam logic [5:0] FN_COMM = 6'h20;

    // detector hysteresis state
    typedef enum logic [1:0] {
        DSO_DET_LOW = 2'b01,
        DSO_DET_HIGH = 2'b10
    } dso_det_t;
endpackage : dso_pkg

// file: src/dso_freq_detect.sv
module dso_freq_detect (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // frequencies and settings
    input wire logic [13:0] out_freq,
    input wire logic [13:0] freq_ref,
    input wire logic [13:0] det_level,
    input wire logic [7:0] det_width,
    // detection results
    output logic agree,
    output logic set_agree,
    output logic det1,
    output logic det2
);
    dso_pkg::dso_det_t det_r, det_nxt;
    logic agree_r, agree_nxt;
    logic set_r, set_nxt;
    logic [14:0] ref_lo, lvl_hi, lvl_lo, f15;

    // widened bounds; lower bounds saturate at zero
    always_comb begin
        f15 = {1'b0, out_freq};
        lvl_hi = {1'b0, det_level} + {7'h00, det_width};
        ref_lo = (freq_ref > {6'h00, det_width}) ?
            {1'b0, freq_ref} - {7'h00, det_width} : 15'h0000;
        lvl_lo = (det_level > {6'h00, det_width}) ?
            {1'b0, det_level} - {7'h00, det_width} : 15'h0000;
    end

    // window flags and hysteresis
    always_comb begin
        agree_nxt = (f15 >= ref_lo) && (out_freq <= freq_ref);
        set_nxt = (f15 >= lvl_lo) && (f15 <= lvl_hi);
        det_nxt = det_r;
        unique case (det_r)
            dso_pkg::DSO_DET_LOW: begin
                if (f15 >= lvl_hi) begin
                    det_nxt = dso_pkg::DSO_DET_HIGH;
                end
            end
            dso_pkg::DSO_DET_HIGH: begin
                if (out_freq < det_level) begin
                    det_nxt = dso_pkg::DSO_DET_LOW;
                end
            end
            default: det_nxt = dso_pkg::DSO_DET_LOW;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            det_r <= dso_pkg::DSO_DET_LOW;
            agree_r <= 1'b0;
            set_r <= 1'b0;
        end else begin
            det_r <= det_nxt;
            agree_r <= agree_nxt;
            set_r <= set_nxt;
        end
    end

    assign agree = agree_r;
    assign set_agree = set_r;
    assign det1 = (det_r == dso_pkg::DSO_DET_HIGH);
    assign det2 = (det_r == dso_pkg::DSO_DET_LOW);
endmodule : dso_freq_detect

// file: src/dso_ref_loss.sv
module dso_ref_loss (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // reference and loss status
    input wire logic [13:0] freq_ref,
    input wire logic ref_loss,
    // settings
    input wire logic loss_action,
    input wire logic [7:0] loss_ratio,
    // reference passed on to the ramp
    output logic [13:0] ref_cmd,
    output logic decel_stop
);
    logic [13:0] last_r, last_nxt;
    logic [13:0] cmd_r, cmd_nxt;
    logic stop_r, stop_nxt;
    logic [21:0] prod;
    logic [21:0] scaled;

    // hold last good reference; compute the ramp's input
    always_comb begin
        prod = last_r * loss_ratio;
        scaled = prod / {14'h0000, dso_pkg::RATIO_DIV};
        last_nxt = ref_loss ? last_r : freq_ref;
        cmd_nxt = freq_ref;
        stop_nxt = 1'b0;
        if (ref_loss) begin
            if (loss_action) begin
                cmd_nxt = (scaled > {8'h00, 14'h3FFF}) ? 14'h3FFF :
                    scaled[13:0];
            end else begin
                cmd_nxt = 14'h0000;
                stop_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            last_r <= 14'h0000;
            cmd_r <= 14'h0000;
            stop_r <= 1'b0;
        end else begin
            last_r <= last_nxt;
            cmd_r <= cmd_nxt;
            stop_r <= stop_nxt;
        end
    end

    assign ref_cmd = cmd_r;
    assign decel_stop = stop_r;
endmodule : dso_ref_loss

// file: src/dso_output_selector.sv
// The address-and-strobe port and the register addresses were left to the implementer.
module dso_output_selector (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // frequency and voltage measurements
    input wire logic [13:0] out_freq,
    input wire logic [13:0] freq_ref,
    input wire logic [9:0] dc_bus,
    // drive conditions from same-clock logic
    input wire logic run_cmd,
    input wire logic fault_other,
    input wire logic comm_error_a,
    input wire logic comm_error_b,
    input wire logic drive_ready,
    input wire logic restart_active,
    input wire logic block_active,
    input wire logic over_torque,
    input wire logic under_torque,
    input wire logic ref_loss,
    input wire logic timer_out,
    input wire logic motor2_sel,
    input wire logic zero_servo_locked,
    input wire logic comm_ctrl_active,
    input wire logic internal_controller_out,
    // local/remote terminal from the digital_inputs pins
    input wire logic local_remote_pin,
    // output terminals
    output logic relay_output_one,
    output logic relay_output_two,
    output logic photo_output,
    // keypad indicators
    output logic run_source_led,
    output logic ref_source_led,
    // reference handling on loss
    output logic [13:0] ref_cmd,
    output logic decel_stop
);
    logic [5:0] func_r [dso_pkg::N_TERM];
    logic [5:0] func_nxt [dso_pkg::N_TERM];
    logic [13:0] level_r, level_nxt;
    logic [7:0] width_r, width_nxt;
    logic [6:0] ctrl_r, ctrl_nxt;
    logic [7:0] ratio_r, ratio_nxt;
    logic [13:0] fmin_r, fmin_nxt;
    logic [9:0] uvlev_r, uvlev_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [2:0] out_r, out_nxt;
    logic s1_r, s2_r, s3_r, lr_r;
    logic lr_nxt;
    logic agree, set_agree, det1, det2;
    logic local_run, local_ref, fault_any;
    logic [1:0] run_src, ref_src;
    logic [13:0] level_cap, lvl_w;
    logic [7:0] wid_w;

    assign run_src = ctrl_r[dso_pkg::CTRL_RUN_LO +: 2];
    assign ref_src = ctrl_r[dso_pkg::CTRL_REF_LO +: 2];

    // window and hysteresis comparisons
    dso_freq_detect u_det (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .out_freq(out_freq),
        .freq_ref(freq_ref),
        .det_level(level_r),
        .det_width(width_r),
        .agree(agree),
        .set_agree(set_agree),
        .det1(det1),
        .det2(det2)
    );

    // loss action on the reference path
    dso_ref_loss u_loss (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .freq_ref(freq_ref),
        .ref_loss(ref_loss),
        .loss_action(ctrl_r[dso_pkg::CTRL_LOSS]),
        .loss_ratio(ratio_r),
        .ref_cmd(ref_cmd),
        .decel_stop(decel_stop)
    );

    // pin synchroniser; level moves once stages two and three agree
    always_comb begin
        lr_nxt = (s2_r == s3_r) ? s3_r : lr_r;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lr_r <= 1'b0;
        end else begin
            s1_r <= local_remote_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lr_r <= lr_nxt;
        end
    end

    // an assigned local/remote terminal overrides settings
    always_comb begin
        local_run = ctrl_r[dso_pkg::CTRL_LR_EN] ? lr_r :
            (run_src == dso_pkg::SRC_LOCAL);
        local_ref = ctrl_r[dso_pkg::CTRL_LR_EN] ? lr_r :
            (ref_src == dso_pkg::SRC_LOCAL);
        // comm errors are no fault here
        fault_any = fault_other;
    end

    // clamp writes into legal ranges
    always_comb begin
        level_cap = ctrl_r[dso_pkg::CTRL_HF] ? dso_pkg::LEVEL_MAX_HF :
            dso_pkg::LEVEL_MAX;
        lvl_w = (reg_wdata[13:0] > level_cap) ? level_cap :
            reg_wdata[13:0];
        wid_w = (reg_wdata[7:0] < dso_pkg::WIDTH_MIN) ?
            dso_pkg::WIDTH_MIN : reg_wdata[7:0];
    end

    // register writes
    always_comb begin
        for (int i = 0; i < dso_pkg::N_TERM; i++) begin
            func_nxt[i] = func_r[i];
        end
        level_nxt = level_r;
        width_nxt = width_r;
        ctrl_nxt = ctrl_r;
        ratio_nxt = ratio_r;
        fmin_nxt = fmin_r;
        uvlev_nxt = uvlev_r;
        // lowering the range clamps a high level
        if (!ctrl_r[dso_pkg::CTRL_HF] && level_r > dso_pkg::LEVEL_MAX) begin
            level_nxt = dso_pkg::LEVEL_MAX;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                dso_pkg::ADR_FUNC0: func_nxt[0] = reg_wdata[5:0];
                dso_pkg::ADR_FUNC1: func_nxt[1] = reg_wdata[5:0];
                dso_pkg::ADR_FUNC2: func_nxt[2] = reg_wdata[5:0];
                dso_pkg::ADR_LEVEL: level_nxt = lvl_w;
                dso_pkg::ADR_WIDTH: width_nxt = wid_w;
                dso_pkg::ADR_CTRL: ctrl_nxt = reg_wdata[6:0];
                dso_pkg::ADR_RATIO: ratio_nxt = reg_wdata[7:0];
                dso_pkg::ADR_FMIN: fmin_nxt = reg_wdata[13:0];
                dso_pkg::ADR_UVLEV: uvlev_nxt = reg_wdata[9:0];
                default: ;
            endcase
        end
    end

    // read data stand one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                dso_pkg::ADR_FUNC0: rdata_nxt = {10'h000, func_r[0]};
                dso_pkg::ADR_FUNC1: rdata_nxt = {10'h000, func_r[1]};
                dso_pkg::ADR_FUNC2: rdata_nxt = {10'h000, func_r[2]};
                dso_pkg::ADR_LEVEL: rdata_nxt = {2'h0, level_r};
                dso_pkg::ADR_WIDTH: rdata_nxt = {8'h00, width_r};
                dso_pkg::ADR_CTRL: rdata_nxt = {9'h000, ctrl_r};
                dso_pkg::ADR_RATIO: rdata_nxt = {8'h00, ratio_r};
                dso_pkg::ADR_FMIN: rdata_nxt = {2'h0, fmin_r};
                dso_pkg::ADR_UVLEV: rdata_nxt = {6'h00, uvlev_r};
                dso_pkg::ADR_STATUS: begin
                    rdata_nxt[dso_pkg::ST_OUT_LO +: 3] = out_r;
                    rdata_nxt[dso_pkg::ST_DET1] = det1;
                    rdata_nxt[dso_pkg::ST_LOC_RUN] = local_run;
                    rdata_nxt[dso_pkg::ST_LOC_REF] = local_ref;
                    rdata_nxt[dso_pkg::ST_LOSS] = ref_loss;
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // one selector per terminal
    genvar t;
    generate
        for (t = 0; t < dso_pkg::N_TERM; t++) begin : g_term
            always_comb begin
                unique case (func_r[t])
                    dso_pkg::FN_RUNNING:
                        out_nxt[t] = run_cmd || (out_freq != 14'h0000);
                    dso_pkg::FN_FAULT: out_nxt[t] = fault_any;
                    dso_pkg::FN_AGREE: out_nxt[t] = agree;
                    dso_pkg::FN_SET_AGREE: out_nxt[t] = set_agree;
                    dso_pkg::FN_DET1: out_nxt[t] = det1;
                    dso_pkg::FN_DET2: out_nxt[t] = det2;
                    dso_pkg::FN_RESTART: out_nxt[t] = restart_active;
                    dso_pkg::FN_BLOCK: out_nxt[t] = block_active;
                    dso_pkg::FN_OVER_TQ: out_nxt[t] = over_torque;
                    dso_pkg::FN_UNDER_TQ: out_nxt[t] = under_torque;
                    dso_pkg::FN_CTRL_SRC:
                        out_nxt[t] = (run_src == dso_pkg::SRC_CTRL);
                    dso_pkg::FN_CTRL_OUT:
                        out_nxt[t] = internal_controller_out;
                    dso_pkg::FN_ZERO_SPD:
                        out_nxt[t] = (out_freq < fmin_r);
                    dso_pkg::FN_READY:
                        out_nxt[t] = drive_ready && !fault_other
                            && !comm_error_a && !comm_error_b;
                    dso_pkg::FN_UNDERV:
                        out_nxt[t] = (dc_bus < uvlev_r);
                    dso_pkg::FN_LOC_RUN: out_nxt[t] = local_run;
                    dso_pkg::FN_LOC_REF: out_nxt[t] = local_ref;
                    dso_pkg::FN_REF_LOSS: out_nxt[t] = ref_loss;
                    dso_pkg::FN_TIMER: out_nxt[t] = timer_out;
                    dso_pkg::FN_MOTOR2: out_nxt[t] = motor2_sel;
                    dso_pkg::FN_ZSERVO:
                        out_nxt[t] = zero_servo_locked;
                    dso_pkg::FN_COMM: out_nxt[t] = comm_ctrl_active;
                    // reserved codes keep the contact open
                    default: out_nxt[t] = 1'b0;
                endcase
            end
        end
    endgenerate

    // state registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < dso_pkg::N_TERM; i++) begin
                func_r[i] <= dso_pkg::FUNC_RST;
            end
            level_r <= dso_pkg::LEVEL_RST;
            width_r <= dso_pkg::WIDTH_RST;
            ctrl_r <= dso_pkg::CTRL_RST;
            ratio_r <= dso_pkg::RATIO_RST;
            fmin_r <= dso_pkg::FMIN_RST;
            uvlev_r <= dso_pkg::UVLEV_RST;
            rdata_r <= 16'h0000;
            out_r <= 3'h0;
        end else begin
            for (int i = 0; i < dso_pkg::N_TERM; i++) begin
                func_r[i] <= func_nxt[i];
            end
            level_r <= level_nxt;
            width_r <= width_nxt;
            ctrl_r <= ctrl_nxt;
            ratio_r <= ratio_nxt;
            fmin_r <= fmin_nxt;
            uvlev_r <= uvlev_nxt;
            rdata_r <= rdata_nxt;
            out_r <= out_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign relay_output_one = out_r[0];
    assign relay_output_two = out_r[1];
    assign photo_output = out_r[2];
    // indicators light in remote mode
    assign run_source_led = !local_run;
    assign ref_source_led = !local_ref;
endmodule : dso_output_selector

// file: verif/dso_output_selector_asserts.sv
module dso_output_selector_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // loss handling
    input wire logic ref_loss,
    input wire logic [13:0] ref_cmd,
    input wire logic decel_stop
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // read strobe at one word address
    sequence rd_at(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // two lost cycles, no write: ratio cannot move
    sequence lost_quiet;
        ref_loss && $past(ref_loss) && !reg_wr && !$past(reg_wr);
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    func_upper_a: assert property (rd_at(4'h0) |=> reg_rdata[15:6] == 10'h000)
        else $error("function code upper bits set");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 4'h9 |=> !reg_rdata)
        else $error("unmapped read not zero");
    width_min_a: assert property (rd_at(4'h4) |=> reg_rdata inside {[1:255]})
        else $error("width out of range");
    level_max_a: assert property (rd_at(4'h3) |=> reg_rdata <= 16'h2EE0)
        else $error("level above range");
    status_upper_a: assert property (rd_at(4'h9) |=> reg_rdata[15:7] == 9'h000)
        else $error("status upper bits set");
    stop_zero_a: assert property (decel_stop |-> ref_cmd == 14'h0000)
        else $error("reference kept while stopping");
    stop_cause_a: assert property (decel_stop |-> $past(ref_loss))
        else $error("stop without reference loss");
    ref_frozen_a: assert property (lost_quiet |=> $stable(ref_cmd))
        else $error("reference moved while lost");
endmodule : dso_output_selector_asserts

bind dso_output_selector dso_output_selector_asserts u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_loss(ref_loss),
    .ref_cmd(ref_cmd), .decel_stop(decel_stop));

// file: verif/dso_load_model.sv
module dso_load_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // terminals from the drive
    input wire logic relay_output_one,
    input wire logic relay_output_two,
    input wire logic photo_output,
    // contacts as the load sees them
    output logic [2:0] sense
);
    timeunit 1ns;
    timeprecision 1ps;
    // pick-up costs a clock; loads never see glitches
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sense <= 3'h0;
        end else begin
            sense <= {photo_output, relay_output_two, relay_output_one};
        end
    end
endmodule : dso_load_model

// file: verif/dso_output_selector_bench.sv
module dso_output_selector_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, q;
    logic [13:0] out_freq = 14'h0000;
    logic [13:0] freq_ref = 14'h0000;
    logic [9:0] dc_bus = 10'h12C;
    logic run_cmd = 1'b0;
    logic lr_pin = 1'b0;
    logic [13:0] cond = 14'h0000;
    logic t1, t2, t3, run_led, ref_led, decel_stop;
    logic [13:0] ref_cmd;
    logic [2:0] sense;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    // one-condition codes and the bit each follows
    logic [5:0] codes [11] = '{6'h01, 6'h06, 6'h09, 6'h0C, 6'h19, 6'h1A,
        6'h1B, 6'h1E, 6'h1F, 6'h20, 6'h13};
    int bits [11] = '{0, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13};
    logic [13:0] fr [6] = '{14'h77, 14'h78, 14'h79, 14'h64, 14'h63, 14'h4F};
    logic [2:0] fx [6] = '{3'b110, 3'b101, 3'b001, 3'b101, 3'b110, 3'b010};
    logic [5:0] rsv [7] = '{6'h07, 6'h08, 6'h0A, 6'h0B, 6'h0D, 6'h1C, 6'h21};

    dso_output_selector DUT (.clk_sys(clk_sys), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq(out_freq),
        .freq_ref(freq_ref), .dc_bus(dc_bus), .run_cmd(run_cmd),
        .fault_other(cond[0]), .comm_error_a(cond[1]),
        .comm_error_b(cond[2]), .drive_ready(cond[3]),
        .restart_active(cond[4]), .block_active(cond[5]),
        .over_torque(cond[6]), .under_torque(cond[7]), .ref_loss(cond[8]),
        .timer_out(cond[9]), .motor2_sel(cond[10]),
        .zero_servo_locked(cond[11]), .comm_ctrl_active(cond[12]),
        .internal_controller_out(cond[13]), .local_remote_pin(lr_pin),
        .relay_output_one(t1), .relay_output_two(t2), .photo_output(t3),
        .run_source_led(run_led), .ref_source_led(ref_led),
        .ref_cmd(ref_cmd), .decel_stop(decel_stop));
    dso_load_model u_load (.clk_sys(clk_sys), .nrst(nrst),
        .relay_output_one(t1), .relay_output_two(t2), .photo_output(t3),
        .sense(sense));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard, well above the run's length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    // pin synchroniser plus load pick-up
    task settle;
        repeat (7) @(posedge clk_sys);
        #1;
    endtask : settle
    task setc(input logic [13:0] c);
        @(posedge clk_sys);
        cond <= c;
        settle();
    endtask : setc
    task env(input logic [13:0] f, input logic [9:0] v, input logic r);
        @(posedge clk_sys);
        out_freq <= f;
        dc_bus <= v;
        run_cmd <= r;
        settle();
    endtask : env

    task test_regs;
        rd(dso_pkg::ADR_WIDTH);
        chk(q, 16'h0014);
        rd(4'hF);
        chk(q, 16'h0000);
        wr(dso_pkg::ADR_LEVEL, 16'h3FFF);
        rd(dso_pkg::ADR_LEVEL);
        chk(q, 16'h0FA0);
        wr(dso_pkg::ADR_CTRL, 16'h0001);
        wr(dso_pkg::ADR_LEVEL, 16'h3FFF);
        rd(dso_pkg::ADR_LEVEL);
        chk(q, 16'h2EE0);
        wr(dso_pkg::ADR_CTRL, 16'h0000);
        wr(dso_pkg::ADR_WIDTH, 16'h0000);
        rd(dso_pkg::ADR_WIDTH);
        chk(q, 16'h0001);
        wr(dso_pkg::ADR_STATUS, 16'h007F);
        rd(dso_pkg::ADR_STATUS);
        chk(q, 16'h0030);
    endtask : test_regs
    task test_simple;
        for (int i = 0; i < 11; i++) begin
            wr(dso_pkg::ADR_FUNC0, {10'h000, codes[i]});
            setc(14'h0000);
            chk(sense[0], 1'b0);
            setc(14'h0001 << bits[i]);
            chk(sense[0], 1'b1);
        end
        wr(dso_pkg::ADR_FUNC0, 16'h0001);
        setc(14'h0006);
        chk(sense[0], 1'b0);
    endtask : test_simple
    task test_mixed;
        wr(dso_pkg::ADR_FUNC0, 16'h0015);
        setc(14'h0008);
        chk(sense[0], 1'b1);
        setc(14'h000A);
        chk(sense[0], 1'b0);
        setc(14'h0000);
        wr(dso_pkg::ADR_FUNC0, 16'h0000);
        env(14'h0000, 10'h12C, 1'b1);
        chk(sense[0], 1'b1);
        env(14'h0001, 10'h12C, 1'b0);
        chk(sense[0], 1'b1);
        env(14'h0000, 10'h12C, 1'b0);
        chk(sense[0], 1'b0);
        wr(dso_pkg::ADR_FUNC0, 16'h0014);
        settle();
        chk(sense[0], 1'b1);
        env(14'h0005, 10'h0BD, 1'b0);
        chk(sense[0], 1'b0);
        wr(dso_pkg::ADR_FUNC0, 16'h0016);
        settle();
        chk(sense[0], 1'b1);
        env(14'h0005, 10'h0BE, 1'b0);
        chk(sense[0], 1'b0);
    endtask : test_mixed
    task test_freq;
        wr(dso_pkg::ADR_LEVEL, 16'h0064);
        wr(dso_pkg::ADR_WIDTH, 16'h0014);
        wr(dso_pkg::ADR_FUNC0, 16'h0004);
        wr(dso_pkg::ADR_FUNC1, 16'h0005);
        wr(dso_pkg::ADR_FUNC2, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            env(fr[i], 10'h12C, 1'b0);
            chk(sense, fx[i]);
        end
        wr(dso_pkg::ADR_FUNC2, 16'h0002);
        @(posedge clk_sys);
        freq_ref <= 14'h0100;
        env(14'h00EC, 10'h12C, 1'b0);
        chk(sense[2], 1'b1);
        env(14'h00EB, 10'h12C, 1'b0);
        chk(sense[2], 1'b0);
        env(14'h0101, 10'h12C, 1'b0);
        chk(sense[2], 1'b0);
    endtask : test_freq
    task test_source;
        wr(dso_pkg::ADR_FUNC0, 16'h0012);
        wr(dso_pkg::ADR_FUNC1, 16'h0017);
        wr(dso_pkg::ADR_FUNC2, 16'h0018);
        wr(dso_pkg::ADR_CTRL, 16'h0006);
        settle();
        chk({run_led, sense}, 4'b1101);
        wr(dso_pkg::ADR_CTRL, 16'h0008);
        settle();
        chk({ref_led, sense}, 4'b1010);
        @(posedge clk_sys);
        lr_pin <= 1'b1;
        wr(dso_pkg::ADR_CTRL, 16'h004E);
        settle();
        chk(sense, 3'b111);
        @(posedge clk_sys);
        lr_pin <= 1'b0;
        settle();
        chk(sense, 3'b001);
    endtask : test_source
    task test_loss;
        @(posedge clk_sys);
        freq_ref <= 14'h03E8;
        wr(dso_pkg::ADR_CTRL, 16'h0020);
        setc(14'h0100);
        chk({decel_stop, ref_cmd}, 15'h0320);
        @(posedge clk_sys);
        freq_ref <= 14'h0010;
        settle();
        chk(ref_cmd, 14'h0320);
        wr(dso_pkg::ADR_CTRL, 16'h0000);
        settle();
        chk({decel_stop, ref_cmd}, 15'h4000);
        setc(14'h0000);
    endtask : test_loss
    task test_reserved;
        wr(dso_pkg::ADR_FUNC1, 16'h0006);
        wr(dso_pkg::ADR_FUNC2, 16'h0000);
        env(14'h0000, 10'h12C, 1'b1);
        setc(14'h3FFF);
        for (int i = 0; i < 7; i++) begin
            wr(dso_pkg::ADR_FUNC0, {10'h000, rsv[i]});
            settle();
            chk(sense, 3'b110);
        end
    endtask : test_reserved

    task end_sim;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // reset, then each scenario
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        test_regs();
        test_simple();
        test_mixed();
        test_freq();
        test_source();
        test_loss();
        test_reserved();
        end_sim();
    end
endmodule : dso_output_selector_bench
